// ### logic/ssch_cmd.sv
// single shot command handler: decode, timing, results, replies, baseline
// assumes framed 16-bit commands and a measurement front end on plain ports
`timescale 1ns/100ps
module ssch_cmd
  import ssch_pkg::*;
#(
  parameter logic [3:0]  VARIANT_CODE = 4'ha,   // arbitrary value
  parameter logic [11:0] VARIANT_LOW  = 12'h3c6, // arbitrary value
  parameter logic [3:0]  BASE_CODE    = 4'hc,   // arbitrary value
  parameter int CYC_VARIANT = ms_to_cyc(T_VARIANT_MS),
  parameter int CYC_SHOT    = ms_to_cyc(T_SHOT_MS),
  parameter int CYC_RHT     = ms_to_cyc(T_RHT_MS),
  parameter int CYC_SLEEP   = ms_to_cyc(T_SLEEP_MS),
  parameter int CYC_WAKE    = ms_to_cyc(T_WAKE_MS),
  parameter int CYC_FACTORY = ms_to_cyc(T_FACTORY_MS)
)(
  input  wire logic        clk,         // 10 MHz clock
  input  wire logic        srst,        // sync reset, power cycle
  input  wire logic        cmd_valid,   // command word strobe
  input  wire logic [15:0] cmd_code,    // command word
  input  wire logic        fetch_req,   // read-measurement strobe
  input  wire logic        rsp_req,     // request next reply byte
  input  wire logic        asc_off,     // 1 disables baseline correction
  input  wire logic [15:0] gas_in,      // front end gas value
  input  wire logic [15:0] hum_in,      // front end humidity value
  input  wire logic [15:0] temp_in,     // front end temperature value
  output logic             cmd_ack,     // command accepted pulse, none for wake
  output logic             cmd_nack,    // command refused pulse, none in sleep
  output logic             busy,        // command executing
  output logic             asleep,      // in sleep
  output logic             meas_start,  // front end start pulse
  output logic             meas_gas,    // start includes gas
  output logic [7:0]       rsp_byte,    // reply byte
  output logic             rsp_valid,   // reply byte pulse
  output logic             rsp_avail,   // reply bytes pending
  output logic             asc_correct  // baseline correction pulse
);
  import ssch_pkg::*;

  ssch_state_e       state_reg;
  ssch_op_e          op_reg;
  ssch_op_e          op_next;
  logic [TMR_W-1:0]  tmr_reg;
  logic [TMR_W-1:0]  lim;
  logic              done;
  logic              known;
  logic              accept;
  logic              fetch_ok;
  logic              supported;
  logic [15:0]       gas_reg;
  logic [15:0]       hum_reg;
  logic [15:0]       temp_reg;
  logic              res_valid_reg;
  logic [15:0]       rw_reg [0:2];
  logic [1:0]        nw_reg;
  logic [1:0]        wsel_reg;
  logic [1:0]        bsel_reg;
  logic [7:0]        crc;
  logic [5:0]        shot_cnt_reg;
  logic [7:0]        blk_cnt_reg;
  logic              first_reg;
  logic [7:0]        period;

  assign supported = VARIANT_CODE != BASE_CODE;

  always_comb
  begin
    known   = 1'b1;
    op_next = OP_VARIANT;
    case (cmd_code)
      CMD_VARIANT:  op_next = OP_VARIANT;
      CMD_SHOT:     op_next = OP_SHOT;
      CMD_SHOT_RHT: op_next = OP_RHT;
      CMD_SLEEP:    op_next = OP_SLEEP;
      CMD_WAKE:     op_next = OP_WAKE;
      CMD_FACTORY:  op_next = OP_FACTORY;
      default:      known   = 1'b0;
    endcase
  end

  // sleep takes only wake; idle takes all but wake; shots need support
  always_comb
  begin
    accept = 1'b0;
    if (cmd_valid && known)
    begin
      if (state_reg == ST_SLEEP)
        accept = op_next == OP_WAKE;
      else if (state_reg == ST_IDLE)
        accept = op_next != OP_WAKE &&
                 (supported || (op_next != OP_SHOT && op_next != OP_RHT));
    end
  end
  assign fetch_ok = fetch_req && !cmd_valid && state_reg == ST_IDLE &&
                    res_valid_reg;

  always_comb
  begin
    case (op_reg)
      OP_VARIANT: lim = TMR_W'(CYC_VARIANT - 1);
      OP_SHOT:    lim = TMR_W'(CYC_SHOT - 1);
      OP_RHT:     lim = TMR_W'(CYC_RHT - 1);
      OP_SLEEP:   lim = TMR_W'(CYC_SLEEP - 1);
      OP_WAKE:    lim = TMR_W'(CYC_WAKE - 1);
      default:    lim = TMR_W'(CYC_FACTORY - 1);
    endcase
  end
  assign done = state_reg == ST_BUSY && tmr_reg == lim;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_VARIANT;
      tmr_reg   <= '0;
    end
    else
    begin
      tmr_reg <= (state_reg == ST_BUSY) ? tmr_reg + 1'b1 : '0;
      case (state_reg)
        ST_IDLE, ST_SLEEP:
          if (accept)
          begin
            state_reg <= ST_BUSY;
            op_reg    <= op_next;
          end
        ST_BUSY:
          if (done)
            state_reg <= (op_reg == OP_SLEEP) ? ST_SLEEP : ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_ack    <= 1'b0;
      cmd_nack   <= 1'b0;
      busy       <= 1'b0;
      asleep     <= 1'b0;
      meas_start <= 1'b0;
      meas_gas   <= 1'b0;
    end
    else
    begin
      cmd_ack    <= (accept && op_next != OP_WAKE) || fetch_ok;
      cmd_nack   <= state_reg != ST_SLEEP &&
                    ((cmd_valid && !accept) ||
                     (fetch_req && !cmd_valid && !fetch_ok));
      busy       <= (state_reg == ST_BUSY && !done) || accept;
      asleep     <= (state_reg == ST_SLEEP && !accept) ||
                    (done && op_reg == OP_SLEEP);
      meas_start <= accept && (op_next == OP_SHOT || op_next == OP_RHT);
      meas_gas   <= accept && op_next == OP_SHOT;
    end
  end

  // result held until fetched or until the next shot completes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gas_reg       <= '0;
      hum_reg       <= '0;
      temp_reg      <= '0;
      res_valid_reg <= 1'b0;
    end
    else if (done && (op_reg == OP_SHOT || op_reg == OP_RHT))
    begin
      gas_reg       <= (op_reg == OP_SHOT) ? gas_in : 16'h0000;
      hum_reg       <= hum_in;
      temp_reg      <= temp_in;
      res_valid_reg <= 1'b1;
    end
    else if (fetch_ok)
      res_valid_reg <= 1'b0;
  end

  ssch_crc8 #(.W(16)) u_crc (
    .data (rw_reg[wsel_reg]),
    .crc  (crc)
  );

  // reply bytes: high, low, checksum per word
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 3; i++)
        rw_reg[i] <= '0;
      nw_reg    <= '0;
      wsel_reg  <= '0;
      bsel_reg  <= '0;
      rsp_avail <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte  <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (done && op_reg == OP_VARIANT)
      begin
        rw_reg[0] <= {VARIANT_CODE, VARIANT_LOW};
        nw_reg    <= 2'd1;
        wsel_reg  <= '0;
        bsel_reg  <= '0;
        rsp_avail <= 1'b1;
      end
      else if (fetch_ok)
      begin
        rw_reg[0] <= gas_reg;
        rw_reg[1] <= hum_reg;
        rw_reg[2] <= temp_reg;
        nw_reg    <= 2'd3;
        wsel_reg  <= '0;
        bsel_reg  <= '0;
        rsp_avail <= 1'b1;
      end
      else if (rsp_req && rsp_avail)
      begin
        rsp_valid <= 1'b1;
        case (bsel_reg)
          2'd0:    rsp_byte <= rw_reg[wsel_reg][15:8];
          2'd1:    rsp_byte <= rw_reg[wsel_reg][7:0];
          default: rsp_byte <= crc;
        endcase
        bsel_reg <= (bsel_reg == 2'd2) ? 2'd0 : bsel_reg + 2'd1;
        if (bsel_reg == 2'd2)
        begin
          wsel_reg <= wsel_reg + 2'd1;
          if (wsel_reg == nw_reg - 2'd1)
            rsp_avail <= 1'b0;
        end
      end
    end
  end

  // baseline correction: shots counted as 5 min, blocks of 4 h
  assign period = first_reg ? 8'(ASC_INIT_BLOCKS) : 8'(ASC_STD_BLOCKS);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shot_cnt_reg <= '0;
      blk_cnt_reg  <= '0;
      first_reg    <= 1'b1;
      asc_correct  <= 1'b0;
    end
    else
    begin
      asc_correct <= 1'b0;
      if (done && op_reg == OP_FACTORY)
      begin
        shot_cnt_reg <= '0;
        blk_cnt_reg  <= '0;
        first_reg    <= 1'b1;
      end
      else if (done && (op_reg == OP_SLEEP || op_reg == OP_WAKE))
      begin
        shot_cnt_reg <= '0;
        blk_cnt_reg  <= '0;
      end
      else if (done && op_reg == OP_SHOT && !asc_off)
      begin
        if (shot_cnt_reg == 6'(SHOTS_PER_BLOCK - 1))
        begin
          shot_cnt_reg <= '0;
          if (blk_cnt_reg == period - 8'd1)
          begin
            blk_cnt_reg <= '0;
            first_reg   <= 1'b0;
            asc_correct <= 1'b1;
          end
          else
            blk_cnt_reg <= blk_cnt_reg + 8'd1;
        end
        else
          shot_cnt_reg <= shot_cnt_reg + 6'd1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  variant_word_a: assert property (
    done && op_reg == OP_VARIANT |=> rsp_avail && nw_reg == 2'd1 &&
      rw_reg[0][15:12] == VARIANT_CODE)
    else $error("variant word wrong");
  base_refuse_a: assert property (
    cmd_valid && !supported && state_reg == ST_IDLE &&
      (cmd_code == CMD_SHOT || cmd_code == CMD_SHOT_RHT)
      |=> cmd_nack && !meas_start && !busy)
    else $error("shot accepted on base variant");
  shot_start_a: assert property (
    accept && op_next == OP_SHOT |=> meas_start && meas_gas && busy)
    else $error("full shot not started");
  rht_zero_a: assert property (
    done && op_reg == OP_RHT |=> gas_reg == 16'h0000 && res_valid_reg)
    else $error("gas not zero after rht shot");
  crc_byte_a: assert property (
    rsp_req && rsp_avail && bsel_reg == 2'd2 && !fetch_ok &&
      !(done && op_reg == OP_VARIANT) |=> rsp_valid &&
      rsp_byte == $past(crc))
    else $error("checksum byte wrong");
  sleep_enter_a: assert property (
    done && op_reg == OP_SLEEP |=> asleep && state_reg == ST_SLEEP)
    else $error("sleep not entered");
  wake_noack_a: assert property (
    accept && op_next == OP_WAKE |=> !cmd_ack ##1 !cmd_ack)
    else $error("wake acknowledged");
  asc_clear_a: assert property (
    done && (op_reg == OP_SLEEP || op_reg == OP_WAKE)
      |=> shot_cnt_reg == 6'd0 && blk_cnt_reg == 8'd0 && !asc_correct)
    else $error("correction history kept over sleep");
  asc_fire_a: assert property (
    asc_correct |-> $past(blk_cnt_reg) == $past(period) - 8'd1 &&
      $past(shot_cnt_reg) == 6'(SHOTS_PER_BLOCK - 1) && !first_reg)
    else $error("correction at wrong count");
  result_hold_a: assert property (
    res_valid_reg && !fetch_ok && !done |=> res_valid_reg &&
      $stable(gas_reg) && $stable(hum_reg))
    else $error("result lost before fetch");
endmodule : ssch_cmd

// ### logic/ssch_crc8.sv
// checksum of one response word, msb first
// assumes the caller registers the result
`timescale 1ns/100ps
module ssch_crc8
  import ssch_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic [W-1:0] data, // word to protect
  output logic      [7:0]   crc   // checksum byte
);
  logic [7:0] c [0:W];

  assign c[0] = CRC_INIT;
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign c[i+1] = {c[i][6:0], 1'b0} ^
                    ((c[i][7] ^ data[W-1-i]) ? CRC_POLY : 8'h00);
  end
  assign crc = c[W];
endmodule : ssch_crc8

// ### shared/ssch_pkg.sv
// constants, command codes and state encodings of the single shot handler
// assumes a 10 MHz clock; command words arrive already framed by the bus
package ssch_pkg;
  localparam logic [15:0] CMD_VARIANT  = 16'h202f;
  localparam logic [15:0] CMD_SHOT     = 16'h219d;
  localparam logic [15:0] CMD_SHOT_RHT = 16'h2196;
  localparam logic [15:0] CMD_SLEEP    = 16'h36e0;
  localparam logic [15:0] CMD_WAKE     = 16'h36f6;
  localparam logic [15:0] CMD_FACTORY  = 16'h3632;

  localparam int CLK_PERIOD_NS = 100;
  localparam int T_VARIANT_MS  = 1;
  localparam int T_SHOT_MS     = 5000;
  localparam int T_RHT_MS      = 50;
  localparam int T_SLEEP_MS    = 1;
  localparam int T_WAKE_MS     = 30;
  localparam int T_FACTORY_MS  = 1200;
  localparam int TMR_W         = 26;

  function automatic int ms_to_cyc(input int ms);
    return ms * (1000000 / CLK_PERIOD_NS);
  endfunction : ms_to_cyc

  localparam int SHOT_INTERVAL_MIN = 5;
  localparam int ASC_BLOCK_HOURS   = 4;
  localparam int SHOTS_PER_BLOCK   = ASC_BLOCK_HOURS * 60 / SHOT_INTERVAL_MIN;
  localparam int ASC_INIT_HOURS    = 44;
  localparam int ASC_STD_HOURS     = 156;
  localparam int ASC_INIT_BLOCKS   = ASC_INIT_HOURS / ASC_BLOCK_HOURS;
  localparam int ASC_STD_BLOCKS    = ASC_STD_HOURS / ASC_BLOCK_HOURS;

  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_SLEEP = 3'b100
  } ssch_state_e;

  typedef enum logic [5:0] {
    OP_VARIANT = 6'b000001,
    OP_SHOT    = 6'b000010,
    OP_RHT     = 6'b000100,
    OP_SLEEP   = 6'b001000,
    OP_WAKE    = 6'b010000,
    OP_FACTORY = 6'b100000
  } ssch_op_e;
endpackage : ssch_pkg

// ### tb/single_shot_command_handler_bench.sv
// bench for the single shot handler, short cycle counts
// assumes the master model drives the command side
`timescale 1ns/100ps
module single_shot_command_handler_bench;
  import ssch_pkg::*;
  localparam int C_SHOT = 8;
  localparam int C_RHT  = 4;
  localparam int C_SLP  = 3;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] gas_in = 16'h0000;
  logic [15:0] hum_in = 16'h0000;
  logic [15:0] temp_in = 16'h0000;
  logic        cmd_valid, fetch_req, rsp_req, hung;
  logic [15:0] cmd_code;
  logic        cmd_ack, cmd_nack, busy, asleep, meas_start, meas_gas;
  logic        rsp_valid, rsp_avail, asc_correct, b_nack;
  logic        asc_off = 1'b0;
  logic        b_ack, b_busy, b_asleep, b_st, b_avail;
  logic [7:0]  rsp_byte;
  int n_errors = 0;
  int tests_run = 0;
  int n_ack = 0, n_nack = 0, n_st = 0, n_gas = 0, n_asc = 0;
  int n_bn = 0, n_busy = 0;
  int n_bst = 0, n_back = 0, n_bbusy = 0;

  always #50 clk = ~clk;

  ssch_cmd #(.CYC_VARIANT(5), .CYC_SHOT(C_SHOT), .CYC_RHT(C_RHT),
    .CYC_SLEEP(C_SLP), .CYC_WAKE(6), .CYC_FACTORY(5)) dut_u (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .fetch_req(fetch_req), .rsp_req(rsp_req), .asc_off(asc_off),
    .gas_in(gas_in), .hum_in(hum_in), .temp_in(temp_in),
    .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .busy(busy), .asleep(asleep),
    .meas_start(meas_start), .meas_gas(meas_gas), .rsp_byte(rsp_byte),
    .rsp_valid(rsp_valid), .rsp_avail(rsp_avail),
    .asc_correct(asc_correct));

  // base variant copy: shots must be refused
  ssch_cmd #(.BASE_CODE(4'ha), .CYC_VARIANT(5), .CYC_SHOT(C_SHOT),
    .CYC_RHT(C_RHT), .CYC_SLEEP(C_SLP), .CYC_WAKE(6),
    .CYC_FACTORY(5)) dut_b (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .fetch_req(fetch_req), .rsp_req(rsp_req), .asc_off(asc_off),
    .gas_in(gas_in), .hum_in(hum_in), .temp_in(temp_in),
    .cmd_ack(b_ack), .cmd_nack(b_nack), .busy(b_busy),
    .asleep(b_asleep), .meas_start(b_st),
    .meas_gas(), .rsp_byte(), .rsp_valid(), .rsp_avail(b_avail),
    .asc_correct());

  ssch_master m_u (
    .clk(clk), .busy(busy), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .fetch_req(fetch_req),
    .rsp_req(rsp_req), .hung(hung));

  // pulse and busy-cycle counters, sampled mid-cycle
  always @(negedge clk)
  begin
    if (cmd_ack === 1'b1) n_ack++;
    if (cmd_nack === 1'b1) n_nack++;
    if (meas_start === 1'b1) n_st++;
    if (meas_gas === 1'b1) n_gas++;
    if (asc_correct === 1'b1) n_asc++;
    if (b_nack === 1'b1) n_bn++;
    if (busy === 1'b1) n_busy++;
    if (b_st === 1'b1) n_bst++;
    if (b_ack === 1'b1) n_back++;
    if (b_busy === 1'b1) n_bbusy++;
  end

  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction : crc_of

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge hung)
  begin
    n_errors++;
    tally_and_finish();
  end

  task automatic read_three(input logic [15:0] g, h, t);
    logic [15:0] e [3];
    logic [15:0] w;
    logic [7:0]  c;
    e = '{g, h, t};
    for (int i = 0; i < 3; i++)
    begin
      m_u.get_word(w, c);
      check(w, e[i]);
      check(c, crc_of(w));
    end
    check(rsp_avail, 1'b0);
  endtask : read_three

  task automatic t_variant();
    logic [15:0] w;
    logic [7:0]  c;
    int a;
    a = n_ack;
    m_u.send(CMD_VARIANT);
    check(n_ack - a, 1);
    m_u.get_word(w, c);
    check(w[15:12], 4'ha);
    check(c, crc_of(w));
    check(rsp_avail, 1'b0);
  endtask : t_variant

  task automatic t_shot();
    int s, g, b, k, bs, ba, bk;
    s = n_st;
    g = n_gas;
    b = n_bn;
    k = n_busy;
    bs = n_bst;
    ba = n_back;
    bk = n_bbusy;
    gas_in = 16'h1234;
    hum_in = 16'h5a5a;
    temp_in = 16'hbeef;
    m_u.send(CMD_SHOT);
    check(n_st - s, 1);
    check(n_gas - g, 1);
    check(n_busy - k, C_SHOT);
    check(n_bn - b, 1);
    check(n_bst - bs, 0);
    check(n_back - ba, 0);
    check(n_bbusy - bk, 0);
    check(rsp_avail, 1'b0);
    m_u.fetch();
    read_three(16'h1234, 16'h5a5a, 16'hbeef);
    check(b_avail, 1'b0);
    s = n_nack;
    m_u.fetch();
    check(n_nack - s, 1);
  endtask : t_shot

  task automatic t_rht();
    int g, k;
    g = n_gas;
    k = n_busy;
    gas_in = 16'h7777;
    m_u.send(CMD_SHOT_RHT);
    check(n_gas - g, 0);
    check(n_busy - k, C_RHT);
    check(rsp_avail, 1'b0);
    m_u.fetch();
    read_three(16'h0000, 16'h5a5a, 16'hbeef);
  endtask : t_rht

  task automatic t_sleep();
    int a, s, k;
    k = n_busy;
    m_u.send(CMD_SLEEP);
    check(asleep, 1'b1);
    check(b_asleep, 1'b1);
    check(n_busy - k, C_SLP);
    a = n_ack;
    s = n_st;
    m_u.send(CMD_SHOT);
    check(n_st - s, 0);
    m_u.send(CMD_WAKE);
    check(n_ack - a, 0);
    check(asleep, 1'b0);
  endtask : t_sleep

  task automatic run_shots(input int n);
    for (int i = 0; i < n; i++)
      m_u.send(CMD_SHOT);
    repeat (2) @(negedge clk);
  endtask : run_shots

  task automatic t_asc();
    int a;
    a = n_asc;
    run_shots(527);
    m_u.send(CMD_SLEEP);
    m_u.send(CMD_WAKE);
    run_shots(527);
    check(n_asc - a, 0);
    run_shots(1);
    check(n_asc - a, 1);
    run_shots(1871);
    check(n_asc - a, 1);
    run_shots(1);
    check(n_asc - a, 2);
  endtask : t_asc

  // factory reset, correction off, then a mid-run power cycle
  task automatic t_factory();
    int a;
    a = n_asc;
    m_u.send(CMD_FACTORY);
    asc_off = 1'b1;
    run_shots(5);
    asc_off = 1'b0;
    run_shots(527);
    check(n_asc - a, 0);
    run_shots(1);
    check(n_asc - a, 1);
    run_shots(100);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    run_shots(527);
    check(n_asc - a, 1);
    run_shots(1);
    check(n_asc - a, 2);
  endtask : t_factory

  initial
  begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    t_variant();
    t_shot();
    t_rht();
    t_sleep();
    t_asc();
    t_factory();
    tally_and_finish();
  end
endmodule : single_shot_command_handler_bench

// ### tb/ssch_master.sv
// bus master model: frames commands, fetches and reply bytes
// assumes the bench calls its tasks; drives on falling edges
`timescale 1ns/100ps
module ssch_master
  import ssch_pkg::*;
#(
  parameter int GAP = 2
)(
  input  wire logic       clk,       // design clock
  input  wire logic       busy,      // device executing
  input  wire logic       rsp_valid, // reply byte pulse
  input  wire logic [7:0] rsp_byte,  // reply byte
  output logic            cmd_valid, // command strobe
  output logic [15:0]     cmd_code,  // command word
  output logic            fetch_req, // read-measurement strobe
  output logic            rsp_req,   // next byte request
  output logic            hung       // a bounded wait ran out
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 16'h0000;
    fetch_req = 1'b0;
    rsp_req   = 1'b0;
    hung      = 1'b0;
  end

  task automatic wait_idle();
    int i;
    @(negedge clk);
    for (i = 0; i < 200 && busy !== 1'b0; i++)
      @(negedge clk);
    if (busy !== 1'b0)
      hung = 1'b1;
  endtask : wait_idle

  task automatic send(input logic [15:0] code);
    if (code == CMD_SHOT || code == CMD_SHOT_RHT)
      repeat (GAP) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    wait_idle(); // wake gives no ack
  endtask : send

  task automatic fetch();
    @(negedge clk);
    fetch_req = 1'b1;
    @(negedge clk);
    fetch_req = 1'b0;
    @(negedge clk);
  endtask : fetch

  task automatic get_byte(output logic [7:0] b);
    int i;
    b = 8'h00;
    @(negedge clk);
    rsp_req = 1'b1;
    @(negedge clk);
    rsp_req = 1'b0;
    for (i = 0; i < 4 && rsp_valid !== 1'b1; i++)
      @(negedge clk);
    if (rsp_valid !== 1'b1)
      hung = 1'b1;
    else
      b = rsp_byte;
  endtask : get_byte

  task automatic get_word(output logic [15:0] w, output logic [7:0] c);
    get_byte(w[15:8]);
    get_byte(w[7:0]);
    get_byte(c);
  endtask : get_word
endmodule : ssch_master
